// File: rvi_unit.v
// Random value instruction unit: random, seed and identification answers
`timescale 1ns/100ps
`default_nettype none
`include "rvi_defs.vh"
// Notes on behaviour
// - A valid random-instruction answer carries carry_flag set to one.
// - When random demand outruns supply the answer carries no data and a clear carry_flag.
// - Self-test marks bad data and the random instruction then returns no data.
// - Leaf 01H reports random-instruction support in bit 30 of the count result register.
// - Leaf 07H subleaf 0 reports seed-instruction support in bit 18 of the base result register.
// - Random values come from a deterministic generator reseeded often from the entropy source.
// - Seed values come from the non-deterministic generator directly, not the deterministic one.
// - A valid seed answer carries carry_flag set to one.
// - When seed demand outruns supply the seed answer carries no data and a clear carry_flag.
// - Self-test marks bad seed data and the seed instruction then returns no data.
// - One successful request returns a full 64-bit value.
module rvi_unit #(
  parameter DATA_W = `RVI_DATA_W
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire req_valid_in,
  input wire req_op_in,
  input wire entropy_bit_in,
  input wire entropy_fault_in,
  input wire [31:0] query_leaf_in,
  input wire [31:0] query_subleaf_in,
  output reg rsp_valid_out,
  output reg [DATA_W-1:0] rsp_data_out,
  output reg carry_flag_out,
  output reg [31:0] base_result_register_out,
  output reg [31:0] count_result_register_out
);

////////////////////////////////////////////////////////////////////////
// Entropy pin synchroniser
reg ent_s1;
reg ent_s2;
reg flt_s1;
reg flt_s2;
always @(posedge clk_in or negedge arst_n_in)
begin
  if (!arst_n_in)
  begin
    ent_s1 <= 1'b0;
    ent_s2 <= 1'b0;
    flt_s1 <= 1'b0;
    flt_s2 <= 1'b0;
  end
  else
  begin
    ent_s1 <= entropy_bit_in;
    ent_s2 <= ent_s1;
    flt_s1 <= entropy_fault_in;
    flt_s2 <= flt_s1;
  end
end

////////////////////////////////////////////////////////////////////////
// LFSR step, shared by both generators
function [DATA_W-1:0] lfsr_step;
  input [DATA_W-1:0] v;
  input inj;
  begin
    lfsr_step = {v[DATA_W-2:0], v[DATA_W-1] ^ v[DATA_W-2] ^ v[DATA_W-4] ^ v[DATA_W-5] ^ inj};
  end
endfunction

// Repetition self-test: stuck or repeating output is bad
function health_bad;
  input [DATA_W-1:0] cur;
  input [DATA_W-1:0] prev;
  begin
    health_bad = (cur == prev) || (cur == {DATA_W{1'b0}}) || (cur == {DATA_W{1'b1}});
  end
endfunction

// Pool stock: one in on refill, one out on use
function [3:0] pool_next;
  input [3:0] pool;
  input refill;
  input used;
  input [3:0] limit;
  begin
    if (refill && !used && pool != limit)
      pool_next = pool + 4'h1;
    else if (used && !refill)
      pool_next = pool - 4'h1;
    else
      pool_next = pool;
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Entropy pool and seed supply
reg [DATA_W-1:0] nondeterministic_bit_generator;
reg [DATA_W-1:0] nondet_prev;
reg [7:0] seed_cnt;
reg [3:0] seed_pool;
reg [15:0] reseed_cnt;
reg [DATA_W-1:0] deterministic_bit_generator;
reg [DATA_W-1:0] det_prev;
reg [3:0] rand_pool;
wire seed_take = req_valid_in && (req_op_in == `RVI_OP_SEED);
wire rand_take = req_valid_in && (req_op_in == `RVI_OP_RAND);
wire seed_refill = (seed_cnt == `RVI_SEED_REFILL_CYCLES);
wire reseed = (reseed_cnt == `RVI_DET_RESEED_CYCLES);
wire seed_bad = flt_s2 || health_bad(nondeterministic_bit_generator, nondet_prev);
wire rand_bad = flt_s2 || health_bad(deterministic_bit_generator, det_prev);
wire seed_ok = (seed_pool != 4'h0) && !seed_bad;
wire rand_ok = (rand_pool != 4'h0) && !rand_bad;
wire seed_used = seed_take && seed_ok;
wire rand_used = rand_take && rand_ok;
wire rand_refill = !flt_s2 && !rand_used;
wire rand_query_hit = (query_leaf_in == `RVI_LEAF_FEATURES);
wire seed_query_hit = (query_leaf_in == `RVI_LEAF_EXTENDED) && (query_subleaf_in == `RVI_SUBLEAF_ZERO);

////////////////////////////////////////////////////////////////////////
// Refill and reseed timers
always @(posedge clk_in or negedge arst_n_in)
begin
  if (!arst_n_in)
  begin
    seed_cnt <= 8'h00;
    reseed_cnt <= 16'h0000;
  end
  else
  begin
    seed_cnt <= seed_refill ? 8'h00 : seed_cnt + 8'h01;
    reseed_cnt <= reseed ? 16'h0000 : reseed_cnt + 16'h0001;
  end
end

////////////////////////////////////////////////////////////////////////
// Nondeterministic generator and seed stock
always @(posedge clk_in or negedge arst_n_in)
begin
  if (!arst_n_in)
  begin
    nondeterministic_bit_generator <= `RVI_LFSR_SEED;
    nondet_prev <= {DATA_W{1'b0}};
    seed_pool <= 4'h0;
  end
  else
  begin
    nondeterministic_bit_generator <= lfsr_step(nondeterministic_bit_generator, ent_s2);
    if (seed_used)
      nondet_prev <= nondeterministic_bit_generator;
    seed_pool <= pool_next(seed_pool, seed_refill, seed_used, `RVI_SEED_POOL_MAX);
  end
end

////////////////////////////////////////////////////////////////////////
// Deterministic generator, reseeded from the entropy pool
always @(posedge clk_in or negedge arst_n_in)
begin
  if (!arst_n_in)
  begin
    deterministic_bit_generator <= ~`RVI_LFSR_SEED;
    det_prev <= {DATA_W{1'b0}};
    rand_pool <= 4'h0;
  end
  else
  begin
    if (reseed && !flt_s2)
      deterministic_bit_generator <= lfsr_step(deterministic_bit_generator ^ nondeterministic_bit_generator, 1'b0);
    else
      deterministic_bit_generator <= lfsr_step(deterministic_bit_generator, 1'b0);
    if (rand_used)
      det_prev <= deterministic_bit_generator;
    rand_pool <= pool_next(rand_pool, rand_refill, rand_used, `RVI_RAND_POOL_MAX);
  end
end

////////////////////////////////////////////////////////////////////////
// Response and identification decode
reg next_carry_flag;
reg [DATA_W-1:0] next_rsp_data;
reg [31:0] next_base_result;
reg [31:0] next_count_result;
always @*
begin
  next_carry_flag = 1'b0;
  next_rsp_data = {DATA_W{1'b0}};
  if (seed_take)
  begin
    next_carry_flag = seed_ok;
    if (seed_ok)
      next_rsp_data = nondeterministic_bit_generator;
  end
  else if (rand_take)
  begin
    next_carry_flag = rand_ok;
    if (rand_ok)
      next_rsp_data = deterministic_bit_generator;
  end
  next_base_result = 32'h0000_0000;
  next_count_result = 32'h0000_0000;
  if (rand_query_hit)
    next_count_result[`RVI_RAND_BIT] = 1'b1;
  if (seed_query_hit)
    next_base_result[`RVI_SEED_BIT] = 1'b1;
end

////////////////////////////////////////////////////////////////////////
// Response registers
always @(posedge clk_in or negedge arst_n_in)
begin
  if (!arst_n_in)
  begin
    rsp_valid_out <= 1'b0;
    rsp_data_out <= {DATA_W{1'b0}};
    carry_flag_out <= 1'b0;
    base_result_register_out <= 32'h0000_0000;
    count_result_register_out <= 32'h0000_0000;
  end
  else
  begin
    rsp_valid_out <= req_valid_in;
    rsp_data_out <= next_rsp_data;
    carry_flag_out <= next_carry_flag;
    base_result_register_out <= next_base_result;
    count_result_register_out <= next_count_result;
  end
end

endmodule // rvi_unit
`default_nettype wire

// File: rvi_defs.vh
// Constants for the random value instruction unit
`ifndef RVI_DEFS_VH
`define RVI_DEFS_VH
`define RVI_DATA_W 64
`define RVI_LEAF_FEATURES 32'h0000_0001
`define RVI_LEAF_EXTENDED 32'h0000_0007
`define RVI_SUBLEAF_ZERO 32'h0000_0000
`define RVI_RAND_BIT 30
`define RVI_SEED_BIT 18
`define RVI_OP_RAND 1'b0
`define RVI_OP_SEED 1'b1
`define RVI_LFSR_SEED 64'hACE1_2468_BDF1_3579
`define RVI_DET_RESEED_CYCLES 16'h0040
`define RVI_RAND_POOL_MAX 4'h8
`define RVI_SEED_REFILL_CYCLES 8'h20
`define RVI_SEED_POOL_MAX 4'h2
`endif

// File: rvi_unit_properties.sv
// Port checker for the random value unit
`timescale 1ns/100ps
`default_nettype none
module rvi_chk #(parameter DATA_W = 64) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic req_valid_in,
  input wire logic req_op_in,
  input wire logic entropy_fault_in,
  input wire logic [31:0] query_leaf_in,
  input wire logic [31:0] query_subleaf_in,
  input wire logic rsp_valid_out,
  input wire logic [DATA_W-1:0] rsp_data_out,
  input wire logic carry_flag_out,
  input wire logic [31:0] base_result_register_out,
  input wire logic [31:0] count_result_register_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_ans; req_valid_in |=> rsp_valid_out; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_idle; !req_valid_in |=> !rsp_valid_out && rsp_data_out == '0; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_nil; rsp_valid_out && !carry_flag_out |-> rsp_data_out == '0; endproperty
  a_nil: assert property (p_nil) else $error("data on fail");
  property p_ok; rsp_valid_out && carry_flag_out |-> rsp_data_out != '0 && rsp_data_out != '1; endproperty
  a_ok: assert property (p_ok) else $error("bad word");
  property p_flt; entropy_fault_in [*3] ##0 req_valid_in |=> !carry_flag_out; endproperty
  a_flt: assert property (p_flt) else $error("fault passed");
  property p_dry; (req_valid_in && req_op_in) [*4] |=>
    !(carry_flag_out && $past(carry_flag_out) && $past(carry_flag_out, 2) && $past(carry_flag_out, 3)); endproperty
  a_dry: assert property (p_dry) else $error("seed overrun");
  property p_cnt; 1'b1 |=> count_result_register_out == {1'b0, $past(query_leaf_in) == 32'h1, 30'h0}; endproperty
  a_cnt: assert property (p_cnt) else $error("count result");
  property p_base; 1'b1 |=> base_result_register_out ==
    {13'h0, $past(query_leaf_in) == 32'h7 && $past(query_subleaf_in) == 32'h0, 18'h0}; endproperty
  a_base: assert property (p_base) else $error("base result");
endmodule // rvi_chk
bind rvi_unit rvi_chk #(.DATA_W(DATA_W)) i_rvi_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .req_valid_in(req_valid_in), .req_op_in(req_op_in), .entropy_fault_in(entropy_fault_in),
  .query_leaf_in(query_leaf_in), .query_subleaf_in(query_subleaf_in), .rsp_valid_out(rsp_valid_out),
  .rsp_data_out(rsp_data_out), .carry_flag_out(carry_flag_out),
  .base_result_register_out(base_result_register_out), .count_result_register_out(count_result_register_out));
`default_nettype wire

// File: rvi_core.sv
// Core model: request strobes, retry on a clear flag
`timescale 1ns/100ps
`default_nettype none
module rvi_core (
  input wire logic clk_in,
  input wire logic carry_flag_in,
  output logic req_valid_out = 1'b0,
  output logic req_op_out = 1'b0
);
  task automatic burst(input logic op, input int n);
    repeat (n)
    begin
      @(posedge clk_in) #1;
      {req_valid_out, req_op_out} = {1'b1, op};
    end
    @(posedge clk_in) #1;
    {req_valid_out, req_op_out} = {1'b0, ~op};
  endtask
  task automatic fetch(input logic op, output int tries);
    for (tries = 1; tries <= 10; tries++)
    begin
      burst(op, 1);
      if (carry_flag_in === 1'b1) break;
    end
  endtask
endmodule // rvi_core
`default_nettype wire

// File: rvi_unit_tb.sv
// Bench for the random value unit
`timescale 1ns/100ps
`default_nettype none
module rvi_unit_tb;
  logic clk_in, arst_n_in = 1'b0, fault = 1'b0, req_valid_in, req_op_in, rsp_valid_out, carry_flag_out;
  logic [31:0] leaf = 32'h0, sub = 32'h0, base, cnt;
  logic [63:0] data;
  logic [7:0] lfsr = 8'h5A;
  logic [127:0] rows [3] = '{{32'h1, 32'h0, 32'h4000_0000, 32'h0}, {32'h7, 32'h0, 32'h0, 32'h4_0000},
    {32'h7, 32'h1, 64'h0}};
  int err_count = 0, check_count = 0, ok_count = 0, n0, tries;
  rvi_unit i_rvi_unit (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in), .req_op_in(req_op_in),
    .entropy_bit_in(lfsr[0]), .entropy_fault_in(fault), .query_leaf_in(leaf), .query_subleaf_in(sub),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(data), .carry_flag_out(carry_flag_out),
    .base_result_register_out(base), .count_result_register_out(cnt));
  rvi_core i_rvi_core (.clk_in(clk_in), .carry_flag_in(carry_flag_out), .req_valid_out(req_valid_in),
    .req_op_out(req_op_in));
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5]};
    ok_count <= ok_count + (rsp_valid_out && carry_flag_out);
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_in);
    check(data, 64'h0);
    #1 arst_n_in = 1'b1;
    foreach (rows[i])
    begin
      {leaf, sub} = rows[i][127:64];
      @(posedge clk_in) #1;
      check({cnt, base}, rows[i][63:0]);
    end
    n0 = ok_count;
    i_rvi_core.burst(1'b0, 4);
    @(posedge clk_in) #1;
    check(64'(ok_count - n0), 64'h4);
    repeat (30) @(posedge clk_in);
    i_rvi_core.fetch(1'b1, tries);
    check({tries <= 10, data == 64'h0}, 64'h2);
    repeat (70) @(posedge clk_in);
    n0 = ok_count;
    i_rvi_core.burst(1'b1, 4);
    @(posedge clk_in) #1;
    check(64'((ok_count - n0) / 2), 64'h1);
    fault = 1'b1;
    repeat (3) @(posedge clk_in);
    i_rvi_core.fetch(1'b0, tries);
    check(64'(tries), 64'hB);
    check(data, 64'h0);
    i_rvi_core.fetch(1'b1, tries);
    check(64'(tries), 64'hB);
    fault = 1'b0;
    i_rvi_core.fetch(1'b0, tries);
    check(64'(tries <= 10), 64'h1);
    repeat (4) @(posedge clk_in);
    #1 n0 = ok_count;
    i_rvi_core.burst(1'b0, 10);
    @(posedge clk_in) #1;
    check({ok_count - n0 >= 8, ok_count - n0 < 10}, 64'h3);
    summarize();
  end
endmodule // rvi_unit_tb
`default_nettype wire
